// >>> logic/ecsm_pkg.sv
// Constants and types shared by the encoder control state machine
package ecsm_pkg;
   // ----------------------------------------------------------------
   // Control and status word bit positions
   // ----------------------------------------------------------------
   localparam int CTL_PRESET_MODE = 11; // Relative (1) or absolute (0) preset
   localparam int CTL_PRESET_REQ = 12; // Request home position set or shift
   localparam int CTL_ABS_REQ = 13; // Request absolute value cyclically
   localparam int CTL_PARK = 14; // Activate parking
   localparam int CTL_ERR_ACK = 15; // Acknowledge sensor error
   localparam int CTL2_PLC = 10; // Control by PLC
   localparam int STS_ACK_SEEN = 11; // Error acknowledgement detected
   localparam int STS_PRESET_DONE = 12; // Preset executed
   localparam int STS_ABS_TX = 13; // Absolute value sent cyclically
   localparam int STS_PARK = 14; // Parking active
   localparam int STS_ERROR = 15; // Sensor error
   localparam int STS2_CTL_REQ = 9; // Control requested
   // ----------------------------------------------------------------
   // Telegram types and acyclic parameter numbers
   // ----------------------------------------------------------------
   localparam logic [7:0] TEL_81 = 8'h51;
   localparam logic [7:0] TEL_83 = 8'h53;
   localparam logic [7:0] TEL_84 = 8'h54;
   localparam logic [15:0] PAR_PRESET32 = 16'hfde8; // 65000
   localparam logic [15:0] PAR_STATUS32 = 16'hfde9; // 65001
   localparam logic [15:0] PAR_PRESET64 = 16'hfdea; // 65002
   localparam logic [15:0] PAR_STATUS64 = 16'hfdeb; // 65003
   localparam logic [15:0] PAR_NV_SAVE = 16'h03cb; // 971
   // ----------------------------------------------------------------
   // Error codes and reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] ERR_NO_CLASS4 = 16'h0001; // Preset without class 4
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [63:0] RST_VALUE = 64'h0;
   // ----------------------------------------------------------------
   // Start-up timing
   // ----------------------------------------------------------------
   localparam int STARTUP_TIME_MS = 500; // Initialisation after parking
   localparam int CLK_KHZ = 125_000; // System clock rate
   localparam int STARTUP_CYCLES = STARTUP_TIME_MS * CLK_KHZ;
   // ----------------------------------------------------------------
   // States, Gray coded along the usual path
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_NORMAL = 3'h0,
      ST_PRESET = 3'h1,
      ST_ERROR = 3'h3,
      ST_ACK = 3'h2,
      ST_PARK = 3'h6,
      ST_STARTUP = 3'h7
   } ecsm_state_type;
endpackage : ecsm_pkg

// >>> logic/ecsm_top.sv
// Control and status state machine of a networked absolute encoder
// Summary of operation
// - Profile 4 uses control word only with PLC bit
// - Profile 3 always accepts control, status2 bit9 zero
// - Telegrams 81-83 mirror control bit13 to status
// - Telegram 84 keeps status bit13 cleared
// - Control bit14 parks, zeroes positions, sets status14
// - Parking clears errors and suppresses alarms
// - Control bit12 runs preset, then status12 set
// - Preset without class 4 reports error
// - Telegrams 81-83 use parameters 65000/65001 only
// - Telegram 84 uses parameters 65002/65003 only
// - Signed presets; negative absolute preset ignored
// - Errors enter error state, status15, code shown
// - Acknowledge sets status bits 11 and 15
// - Unparking runs start-up, status14 clears after 500ms
// - Parameter 971 set stores preset non-volatile
`timescale 1ns/1ps
module ecsm_top #(
   parameter int STARTUP_CYCLES = ecsm_pkg::STARTUP_CYCLES, // Start-up wait
   parameter int CNT_W = $clog2(STARTUP_CYCLES + 1) // Start-up counter width
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Configuration
   input wire logic profile_v4_i, // Profile 4 (1) or 3 (0)
   input wire logic [7:0] telegram_i, // Telegram type in use
   input wire logic class4_en_i, // Class 4 functions enabled
   // Cyclic control words from the controller
   input wire logic [15:0] primary_control_word_i,
   input wire logic [15:0] secondary_control_word_i,
   // Sensor side
   input wire logic [63:0] raw_position_i, // Measured position
   input wire logic sensor_error_i, // Error event
   input wire logic [15:0] sensor_error_code_i, // Code of that error
   // Acyclic parameter access
   input wire logic param_req_i, // One-cycle request
   input wire logic param_write_i, // Write (1) or read (0)
   input wire logic [15:0] param_num_i, // Parameter number
   input wire logic [63:0] param_wdata_i, // Write value
   output logic param_ack_o, // One-cycle answer
   output logic param_err_o, // Answer carries an error
   output logic [63:0] param_rdata_o, // Read value
   // Cyclic status and position words
   output logic [15:0] primary_status_word_o,
   output logic [15:0] secondary_status_word_o,
   output logic [31:0] position_word_one_o,
   output logic [31:0] position_word_two_o,
   output logic [63:0] position_word_three_o,
   // Alarm and non-volatile store
   output logic alarm_o, // Error alarm raised
   output logic nv_store_o, // One-cycle store strobe
   output logic [63:0] nv_data_o // Position offset from the preset, to store
);
   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      ecsm_pkg::ecsm_state_type state; // Main state
      logic [15:0] ctl; // Last accepted control word
      logic [63:0] preset; // Loaded preset value, signed
      logic [63:0] offset; // Position offset from presets
      logic [15:0] err_code; // Latched error code
      logic nv_en; // Non-volatile save enabled
      logic [CNT_W-1:0] cnt; // Start-up counter
      logic done; // Preset executed flag
      logic [15:0] sts1; // Primary status word
      logic [15:0] sts2; // Secondary status word
      logic [31:0] pos1; // Position word one
      logic [31:0] pos2; // Position word two
      logic [63:0] pos3; // Position word three
      logic alarm; // Alarm output
      logic par_ack; // Parameter answer strobe
      logic par_err; // Parameter answer error
      logic [63:0] par_rdata; // Parameter read value
      logic nv_store; // Store strobe
      logic [63:0] nv_data; // Store value
   } ecsm_regs_type;

   ecsm_regs_type state_reg; // Registered state
   ecsm_regs_type state_next; // Next state

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Telegram with 32-bit position words
   function automatic logic is_tel32(input logic [7:0] tel);
      is_tel32 = (tel >= ecsm_pkg::TEL_81) && (tel <= ecsm_pkg::TEL_83);
   endfunction : is_tel32

   // Telegram with 64-bit position words
   function automatic logic is_tel64(input logic [7:0] tel);
      is_tel64 = (tel == ecsm_pkg::TEL_84);
   endfunction : is_tel64

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   logic [15:0] ctl_eff; // Control word in force this cycle
   logic [63:0] pos_now; // Position after offset
   logic [CNT_W-1:0] cnt_last; // Final start-up count

   // Control word in force and derived position
   always_comb begin
      cnt_last = CNT_W'(STARTUP_CYCLES - 1);
      // Profile 4 holds the old word unless PLC control is on
      if (profile_v4_i && !secondary_control_word_i[ecsm_pkg::CTL2_PLC]) begin
         ctl_eff = state_reg.ctl;
      end else begin
         ctl_eff = primary_control_word_i;
      end
      pos_now = raw_position_i + state_reg.offset;
   end

   // Main state record update
   always_comb begin
      state_next = state_reg;
      state_next.ctl = ctl_eff;
      state_next.par_ack = 1'b0;
      state_next.par_err = 1'b0;
      state_next.nv_store = 1'b0;

      // Status12 falls when the request falls
      if (!ctl_eff[ecsm_pkg::CTL_PRESET_REQ]) begin
         state_next.done = 1'b0;
      end

      // Acyclic parameter handling
      if (param_req_i) begin
         state_next.par_ack = 1'b1;
         state_next.par_rdata = ecsm_pkg::RST_VALUE;
         if (param_write_i && param_num_i == ecsm_pkg::PAR_PRESET32) begin
            // 32-bit preset only with telegrams 81-83, sign extended
            if (is_tel32(telegram_i)) begin
               state_next.preset = {{32{param_wdata_i[31]}}, param_wdata_i[31:0]};
            end else begin
               state_next.par_err = 1'b1;
            end
         end else if (param_write_i && param_num_i == ecsm_pkg::PAR_PRESET64) begin
            // 64-bit preset only with telegram 84
            if (is_tel64(telegram_i)) begin
               state_next.preset = param_wdata_i;
            end else begin
               state_next.par_err = 1'b1;
            end
         end else if (param_write_i && param_num_i == ecsm_pkg::PAR_NV_SAVE) begin
            // Enable keeping presets over power loss
            state_next.nv_en = (param_wdata_i == 64'h1);
         end else if (!param_write_i && param_num_i == ecsm_pkg::PAR_STATUS32 &&
                      is_tel32(telegram_i)) begin
            // Operating status for telegrams 81-83
            state_next.par_rdata = {32'h0, state_reg.sts2, state_reg.sts1};
         end else if (!param_write_i && param_num_i == ecsm_pkg::PAR_STATUS64 &&
                      is_tel64(telegram_i)) begin
            // Operating status for telegram 84
            state_next.par_rdata = {32'h0, state_reg.sts2, state_reg.sts1};
         end else if (!param_write_i && param_num_i == ecsm_pkg::PAR_NV_SAVE) begin
            // Read back the save setting
            state_next.par_rdata = {63'h0, state_reg.nv_en};
         end else begin
            // Wrong telegram pairing or unknown parameter
            state_next.par_err = 1'b1;
         end
      end

      // State transitions
      if (ctl_eff[ecsm_pkg::CTL_PARK] && state_reg.state != ecsm_pkg::ST_PARK) begin
         // Parking wins from any state, pending errors dropped
         state_next.state = ecsm_pkg::ST_PARK;
         state_next.err_code = ecsm_pkg::RST_WORD;
      end else begin
         unique case (state_reg.state)
            // Normal operation: errors, then preset requests
            ecsm_pkg::ST_NORMAL: begin
               if (sensor_error_i) begin
                  state_next.state = ecsm_pkg::ST_ERROR;
                  state_next.err_code = sensor_error_code_i;
               end else if (ctl_eff[ecsm_pkg::CTL_PRESET_REQ] && !state_reg.done) begin
                  state_next.state = ecsm_pkg::ST_PRESET;
               end
            end
            // Preset: checks, then position update
            ecsm_pkg::ST_PRESET: begin
               if (sensor_error_i) begin
                  state_next.state = ecsm_pkg::ST_ERROR;
                  state_next.err_code = sensor_error_code_i;
               end else if (!class4_en_i) begin
                  state_next.state = ecsm_pkg::ST_ERROR;
                  state_next.err_code = ecsm_pkg::ERR_NO_CLASS4;
               end else begin
                  state_next.state = ecsm_pkg::ST_NORMAL;
                  state_next.done = 1'b1;
                  if (ctl_eff[ecsm_pkg::CTL_PRESET_MODE]) begin
                     // Relative: shift by the signed value
                     state_next.offset = state_reg.offset + state_reg.preset;
                     state_next.nv_store = state_reg.nv_en;
                     state_next.nv_data = state_reg.offset + state_reg.preset;
                  end else if (!state_reg.preset[63]) begin
                     // Absolute: position becomes the value
                     state_next.offset = state_reg.preset - raw_position_i;
                     state_next.nv_store = state_reg.nv_en;
                     state_next.nv_data = state_reg.preset - raw_position_i;
                  end
                  // Negative absolute value leaves offset unchanged
               end
            end
            // Error: wait for acknowledgement
            ecsm_pkg::ST_ERROR: begin
               if (ctl_eff[ecsm_pkg::CTL_ERR_ACK]) begin
                  state_next.state = ecsm_pkg::ST_ACK;
               end
            end
            // Acknowledged: back to normal when the request drops
            ecsm_pkg::ST_ACK: begin
               if (!ctl_eff[ecsm_pkg::CTL_ERR_ACK] && !sensor_error_i) begin
                  state_next.state = ecsm_pkg::ST_NORMAL;
                  state_next.err_code = ecsm_pkg::RST_WORD;
               end
            end
            // Parking: start up once the request is gone
            ecsm_pkg::ST_PARK: begin
               state_next.cnt = '0;
               if (!ctl_eff[ecsm_pkg::CTL_PARK]) begin
                  state_next.state = ecsm_pkg::ST_STARTUP;
               end
            end
            // Start-up: initialisation delay
            ecsm_pkg::ST_STARTUP: begin
               if (state_reg.cnt == cnt_last) begin
                  state_next.state = ecsm_pkg::ST_NORMAL;
               end else begin
                  state_next.cnt = state_reg.cnt + 1'b1;
               end
            end
            // Illegal codes fall back to normal
            default: begin
               state_next.state = ecsm_pkg::ST_NORMAL;
            end
         endcase
      end

      // Status word one from the next state
      state_next.sts1 = ecsm_pkg::RST_WORD;
      state_next.sts1[ecsm_pkg::STS_ACK_SEEN] = (state_next.state == ecsm_pkg::ST_ACK);
      state_next.sts1[ecsm_pkg::STS_PRESET_DONE] = state_next.done;
      state_next.sts1[ecsm_pkg::STS_ABS_TX] = is_tel32(telegram_i) &&
                                              ctl_eff[ecsm_pkg::CTL_ABS_REQ];
      state_next.sts1[ecsm_pkg::STS_PARK] = (state_next.state == ecsm_pkg::ST_PARK) ||
                                            (state_next.state == ecsm_pkg::ST_STARTUP);
      state_next.sts1[ecsm_pkg::STS_ERROR] = (state_next.state == ecsm_pkg::ST_ERROR) ||
                                             (state_next.state == ecsm_pkg::ST_ACK);
      // Status word two: control requested only under profile 4
      state_next.sts2 = ecsm_pkg::RST_WORD;
      state_next.sts2[ecsm_pkg::STS2_CTL_REQ] = profile_v4_i;

      // Alarm only outside parking and start-up
      state_next.alarm = state_next.sts1[ecsm_pkg::STS_ERROR];

      // Position words
      if (state_next.sts1[ecsm_pkg::STS_PARK]) begin
         state_next.pos1 = 32'h0;
         state_next.pos2 = 32'h0;
         state_next.pos3 = 64'h0;
      end else begin
         state_next.pos1 = pos_now[31:0];
         state_next.pos3 = pos_now;
         if (state_next.sts1[ecsm_pkg::STS_ERROR]) begin
            state_next.pos2 = {16'h0, state_next.err_code};
         end else if (is_tel64(telegram_i)) begin
            state_next.pos2 = 32'h0;
         end else begin
            state_next.pos2 = pos_now[31:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Asynchronous reset to constants
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= '0;
         state_reg.state <= ecsm_pkg::ST_NORMAL;
      end else begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, straight from the state register
   // ----------------------------------------------------------------
   assign param_ack_o = state_reg.par_ack;
   assign param_err_o = state_reg.par_err;
   assign param_rdata_o = state_reg.par_rdata;
   assign primary_status_word_o = state_reg.sts1;
   assign secondary_status_word_o = state_reg.sts2;
   assign position_word_one_o = state_reg.pos1;
   assign position_word_two_o = state_reg.pos2;
   assign position_word_three_o = state_reg.pos3;
   assign alarm_o = state_reg.alarm;
   assign nv_store_o = state_reg.nv_store;
   assign nv_data_o = state_reg.nv_data;
endmodule : ecsm_top

// >>> verification/ecsm_checker.sv
// Concurrent checks on the ports of the encoder control state machine
`timescale 1ns/1ps
module ecsm_checker (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Inputs watched
   input wire logic profile_v4_i,
   input wire logic [7:0] telegram_i,
   input wire logic [15:0] primary_control_word_i,
   input wire logic [15:0] secondary_control_word_i,
   input wire logic sensor_error_i,
   input wire logic [15:0] sensor_error_code_i,
   input wire logic param_req_i,
   input wire logic param_write_i,
   input wire logic [15:0] param_num_i,
   // Outputs watched
   input wire logic param_ack_o,
   input wire logic param_err_o,
   input wire logic [15:0] primary_status_word_o,
   input wire logic [31:0] position_word_one_o,
   input wire logic [31:0] position_word_two_o,
   input wire logic [63:0] position_word_three_o,
   input wire logic alarm_o
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   logic [15:0] pc; // Primary control word
   logic [15:0] sts; // Primary status word
   logic acc; // Primary word accepted
   logic t8x; // 32-bit telegram in use
   assign pc = primary_control_word_i;
   assign sts = primary_status_word_o;
   assign acc = !profile_v4_i || secondary_control_word_i[10];
   assign t8x = telegram_i >= ecsm_pkg::TEL_81 && telegram_i <= ecsm_pkg::TEL_83;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   property p_gate; (!acc && t8x)[*2] |=> $stable(sts[13]); endproperty
   a_gate: assert property (p_gate) else $error("ignored word used");
   property p_mirror; t8x && !profile_v4_i |=> sts[13] == $past(pc[13]); endproperty
   a_mirror: assert property (p_mirror) else $error("bit13 mirror");
   property p_tel84; telegram_i == ecsm_pkg::TEL_84 |=> !sts[13]; endproperty
   a_tel84: assert property (p_tel84) else $error("abs bit set under 84");
   property p_park;
      acc && pc[14] |=> sts[14] && position_word_one_o == 32'h0 && position_word_two_o == 32'h0
         && position_word_three_o == 64'h0;
   endproperty
   a_park: assert property (p_park) else $error("no parking");
   property p_quiet; sts[14] |-> !alarm_o && !sts[15]; endproperty
   a_quiet: assert property (p_quiet) else $error("alarm while parked");
   property p_err;
      !profile_v4_i && !pc[14] && !pc[12] && sensor_error_i && sts[15:14] == 2'h0
         |=> sts[15] && alarm_o && position_word_two_o == {16'h0, $past(sensor_error_code_i)};
   endproperty
   a_err: assert property (p_err) else $error("no error");
   property p_ack; !profile_v4_i && !pc[14] && pc[15] && sts[15] |=> sts[11] && sts[15]; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_startup; $fell(pc[14]) && acc && sts[14] |=> sts[14] [*8]; endproperty
   a_startup: assert property (p_startup) else $error("park cleared too early");
   property p_redone; acc && !pc[12] && !pc[14] && sts[12] && !sts[15] |=> !sts[12]; endproperty
   a_redone: assert property (p_redone) else $error("preset done stuck");
   property p_refuse;
      param_req_i && param_write_i && ((param_num_i == ecsm_pkg::PAR_PRESET64 && t8x) ||
         (param_num_i == ecsm_pkg::PAR_PRESET32 && telegram_i == ecsm_pkg::TEL_84))
         |=> param_ack_o && param_err_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("wrong width taken");
endmodule : ecsm_checker

// >>> verification/ecsm_plc_model.sv
// Controller model: cyclic control words and acyclic parameter access
`timescale 1ns/1ps
module ecsm_plc_model (
   // Clock
   input wire logic sys_clk_i,
   // Parameter answer
   input wire logic param_ack_i,
   input wire logic param_err_i,
   input wire logic [63:0] param_rdata_i,
   // Control words and requests
   output logic [15:0] ctl_one_o,
   output logic [15:0] ctl_two_o,
   output logic req_o,
   output logic write_o,
   output logic [15:0] num_o,
   output logic [63:0] wdata_o
);
   // Idle values at time zero
   initial begin
      ctl_one_o = 16'h0000;
      ctl_two_o = 16'h0000;
      req_o = 1'b0;
      write_o = 1'b0;
      num_o = 16'h0000;
      wdata_o = 64'h0;
   end
   // Both control words change just after an edge
   task automatic put(input logic [15:0] one, input logic [15:0] two);
      @(posedge sys_clk_i);
      #1;
      ctl_one_o = one;
      ctl_two_o = two;
   endtask : put
   // One-cycle request; number and value sent as given, answer sampled one cycle later
   task automatic access(input logic wr, input logic [15:0] num, input logic [63:0] d,
         output logic err, output logic [63:0] rd, output logic ok);
      @(posedge sys_clk_i);
      #1;
      req_o = 1'b1;
      write_o = wr;
      num_o = num;
      wdata_o = d;
      @(posedge sys_clk_i);
      #1;
      // Released qualifiers show no stale value
      req_o = 1'b0;
      write_o = ~wr;
      num_o = ~num;
      wdata_o = ~d;
      ok = (param_ack_i === 1'b1);
      err = param_err_i;
      rd = param_rdata_i;
   endtask : access
endmodule : ecsm_plc_model

// >>> verification/ecsm_top_bench.sv
// Self-checking testbench of the encoder control state machine
`timescale 1ns/1ps
module ecsm_top_bench;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int SU = 20; // Shortened start-up wait
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic profile_v4_i = 1'b0;
   logic [7:0] telegram_i = ecsm_pkg::TEL_81;
   logic class4_en_i = 1'b1;
   logic [63:0] raw_position_i = 64'h1000;
   logic sensor_error_i = 1'b0;
   logic [15:0] sensor_error_code_i = 16'h0000;
   wire logic [15:0] primary_control_word_i, secondary_control_word_i, param_num_i;
   wire logic param_req_i, param_write_i, param_ack_o, param_err_o, alarm_o, nv_store_o;
   wire logic [63:0] param_wdata_i, param_rdata_o, position_word_three_o, nv_data_o;
   wire logic [15:0] primary_status_word_o, secondary_status_word_o;
   wire logic [31:0] position_word_one_o, position_word_two_o;
   int bad_count = 0;
   int checked = 0;
   logic perr, pok; // Parameter answer
   logic [63:0] prd; // Parameter read data
   // Design and controller
   ecsm_top #(.STARTUP_CYCLES(SU)) dut (.*);
   ecsm_plc_model plc (.sys_clk_i, .param_ack_i(param_ack_o), .param_err_i(param_err_o),
      .param_rdata_i(param_rdata_o), .ctl_one_o(primary_control_word_i),
      .ctl_two_o(secondary_control_word_i), .req_o(param_req_i), .write_o(param_write_i),
      .num_o(param_num_i), .wdata_o(param_wdata_i));
   always #4 sys_clk_i = ~sys_clk_i;
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : tick
   task automatic chk(input logic ok, input string what);
      checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("ERROR at %0t: %s", $time, what);
      end
   endtask : chk
   task automatic par(input logic wr, input logic [15:0] num, input logic [63:0] d);
      plc.access(wr, num, d, perr, prd, pok);
      chk(pok, "no answer");
   endtask : par
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : complete_run
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   // Control gating, mirror of bit 13 and telegram 84
   task automatic t_cyclic();
      plc.put(16'h2000, 16'h0000);
      tick(1);
      chk(primary_status_word_o[13] === 1'b1, "bit13 mirror");
      chk(secondary_status_word_o[9] === 1'b0, "bit9 set");
      plc.put(16'h0000, 16'h0000);
      tick(1);
      chk(primary_status_word_o[13] === 1'b0, "bit13 stuck");
      profile_v4_i = 1'b1;
      plc.put(16'h2000, 16'h0000);
      tick(1);
      chk(primary_status_word_o[13] === 1'b0, "word used");
      plc.put(16'h2000, 16'h0400);
      tick(1);
      chk(primary_status_word_o[13] === 1'b1, "word ignored");
      telegram_i = ecsm_pkg::TEL_84;
      tick(1);
      chk(primary_status_word_o[13] === 1'b0, "bit13 under 84");
      telegram_i = ecsm_pkg::TEL_81;
      profile_v4_i = 1'b0;
      plc.put(16'h0000, 16'h0000);
   endtask : t_cyclic
   // Presets, store and parameter widths
   task automatic t_preset();
      par(1'b1, ecsm_pkg::PAR_NV_SAVE, 64'h1);
      par(1'b1, ecsm_pkg::PAR_PRESET32, 64'hffff_fff0);
      chk(perr === 1'b0, "preset 32 refused");
      plc.put(16'h1800, 16'h0000);
      tick(2);
      chk(primary_status_word_o[12] === 1'b1, "no preset done");
      chk(nv_store_o === 1'b1 && nv_data_o === 64'hffff_ffff_ffff_fff0, "no store");
      tick(1);
      chk(position_word_three_o === 64'h0ff0, "relative wrong");
      plc.put(16'h0800, 16'h0000);
      tick(1);
      chk(primary_status_word_o[12] === 1'b0, "done not cleared");
      par(1'b1, ecsm_pkg::PAR_PRESET32, 64'hffff_ff00);
      plc.put(16'h1000, 16'h0000);
      tick(2);
      chk(nv_store_o === 1'b0, "neg abs stored");
      tick(1);
      chk(position_word_three_o === 64'h0ff0, "neg abs applied");
      plc.put(16'h0000, 16'h0000);
      par(1'b1, ecsm_pkg::PAR_PRESET32, 64'h0100);
      plc.put(16'h1000, 16'h0000);
      tick(3);
      chk(position_word_one_o === 32'h0100, "absolute wrong");
      plc.put(16'h0000, 16'h0000);
      par(1'b1, ecsm_pkg::PAR_PRESET64, 64'h5);
      chk(perr === 1'b1, "preset 64 taken under 81");
      par(1'b0, ecsm_pkg::PAR_STATUS32, 64'h0);
      chk(perr === 1'b0 && prd === 64'h0, "status 32 refused");
      telegram_i = ecsm_pkg::TEL_84;
      par(1'b1, ecsm_pkg::PAR_PRESET32, 64'h5);
      chk(perr === 1'b1, "preset 32 taken under 84");
      par(1'b0, ecsm_pkg::PAR_STATUS64, 64'h0);
      chk(perr === 1'b0, "status 64 refused");
      telegram_i = ecsm_pkg::TEL_81;
   endtask : t_preset
   // Errors, acknowledge, parking and start-up
   task automatic t_fault();
      int n;
      class4_en_i = 1'b0;
      plc.put(16'h1000, 16'h0000);
      tick(2);
      chk(primary_status_word_o[15] === 1'b1 && position_word_two_o === 32'h1, "no err");
      plc.put(16'h8000, 16'h0000);
      tick(1);
      chk(primary_status_word_o[15:11] === 5'h11, "no ack");
      plc.put(16'h0000, 16'h0000);
      tick(1);
      chk(primary_status_word_o[15] === 1'b0 && alarm_o === 1'b0, "error kept");
      class4_en_i = 1'b1;
      sensor_error_code_i = 16'h0abc;
      sensor_error_i = 1'b1;
      tick(1);
      sensor_error_i = 1'b0;
      chk(primary_status_word_o[15] === 1'b1 && alarm_o === 1'b1, "no sensor error");
      chk(position_word_two_o === 32'h0abc, "no error code");
      plc.put(16'h4000, 16'h0000);
      tick(1);
      chk(primary_status_word_o[15:14] === 2'h1 && alarm_o === 1'b0, "park error");
      chk(position_word_one_o === 32'h0 && position_word_two_o === 32'h0, "pos");
      chk(position_word_three_o === 64'h0, "pos3");
      sensor_error_i = 1'b1;
      tick(1);
      sensor_error_i = 1'b0;
      chk(alarm_o === 1'b0 && primary_status_word_o[15] === 1'b0, "alarm parked");
      plc.put(16'h0000, 16'h0000);
      n = 0;
      while (primary_status_word_o[14] === 1'b1 && n < 60) begin
         tick(1);
         n++;
      end
      chk(n >= SU - 2 && n <= SU + 2, "start-up length");
   endtask : t_fault
   // Main sequence
   initial begin
      repeat (5) @(posedge sys_clk_i);
      #1;
      rst_i = 1'b0;
      tick(1);
      t_cyclic();
      t_preset();
      t_fault();
      complete_run();
   end
   // Watchdog
   initial begin
      #50000;
      bad_count++;
      complete_run();
   end
endmodule : ecsm_top_bench
bind ecsm_top ecsm_checker checker_i (.*);
